// ==== rtl/bit_sync.sv ====
`timescale 1ns/1ns
module bit_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r;

   // first stage is read only by the second stage
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= '0;
         q <= '0;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule

// ==== rtl/i2c_bus_if.sv ====
`timescale 1ns/1ns
interface i2c_bus_if;
   logic m_scl_o;
   logic m_scl_oe;
   logic m_sda_o;
   logic m_sda_oe;
   logic s_scl_o;
   logic s_scl_oe;
   logic s_sda_o;
   logic s_sda_oe;
   logic bus_clock_line;
   logic bus_data_line;

   // ----------------------------------------
   // wired-and with pull-up: low while any driver pulls low
   // ----------------------------------------
   assign bus_clock_line = !((m_scl_oe && !m_scl_o) || (s_scl_oe && !s_scl_o));
   assign bus_data_line = !((m_sda_oe && !m_sda_o) || (s_sda_oe && !s_sda_o));

   modport device (
      output m_scl_o,
      output m_scl_oe,
      output m_sda_o,
      output m_sda_oe,
      input bus_clock_line,
      input bus_data_line
   );

   modport partner (
      output s_scl_o,
      output s_scl_oe,
      output s_sda_o,
      output s_sda_oe,
      input bus_clock_line,
      input bus_data_line
   );
endinterface

// ==== rtl/i2c_engine_pkg.sv ====
package i2c_engine_pkg;

   // ----------------------------------------
   // commands from the user side of the master end
   // ----------------------------------------
   typedef enum logic [1:0] {
      CMD_START = 2'h0,
      CMD_WRITE = 2'h1,
      CMD_READ  = 2'h2,
      CMD_STOP  = 2'h3
   } cmd_t;

   // ----------------------------------------
   // framing and timing
   // ----------------------------------------
   localparam logic [7:0] QUARTER_CYCLES = 8'h04;
   localparam logic [3:0] BIT_ACK = 4'h8;
   localparam logic [3:0] BIT_FIRST = 4'h0;
   localparam logic [6:0] SLAVE_ADDR_DEFAULT = 7'h2A;

endpackage

// ==== rtl/i2c_master_end.sv ====
`timescale 1ns/1ns
// Summary of operation
// - line low when pulled, else high
// - start is data falling, clock high
// - bytes shifted most significant bit first
// - direction bit one reads, zero writes
// - present slave acks, roles then complementary
// - acknowledge is data held low
// - data bits change only while clock low
// - slave acks writes, master acks reads
// - stop is data rising, clock high
// - repeated start may replace the stop
// - master waits while slave holds clock
// - track bus busy, start only when idle
// - data mismatch loses, release both lines
// - after loss wait for stop first
// - lower address wins, data phase continues
// - nine bit segment, ack sampled ninth
// - master clocks, sample on rising edge
// - enable makes both pins open drain
// - pin output value tied to zero
module i2c_master_end #(
   parameter logic [7:0] QUARTER = i2c_engine_pkg::QUARTER_CYCLES
) (
   input wire logic REF_CLK,
   input wire logic RESET_N,
   input wire logic LINK_CLK,
   i2c_bus_if.device BUS,
   input wire logic SERIAL_PORT_ENABLE,
   input wire logic CMD_VALID,
   input wire logic [1:0] CMD,
   input wire logic [7:0] CMD_DATA,
   input wire logic CMD_NACK,
   output logic CMD_READY,
   output logic DONE,
   output logic [7:0] RX_DATA,
   output logic NACK_SEEN,
   output logic ARB_LOST,
   output logic BUS_BUSY
);
   typedef enum logic [3:0] {
      ST_IDLE  = 4'h1,
      ST_START = 4'h2,
      ST_BIT   = 4'h4,
      ST_STOP  = 4'h8
   } mstate_t;

   // ----------------------------------------
   // user side, reference clock
   // ----------------------------------------
   logic ready_r;
   logic req_tog_r;
   logic done_prev_r;
   logic done_r;
   logic [1:0] cmd_hold_r;
   logic [7:0] data_hold_r;
   logic nack_hold_r;
   logic [7:0] rx_out_r;
   logic nack_out_r;
   logic arb_out_r;
   logic [1:0] back_s;
   logic done_tog_r;
   logic busy_r;
   logic [7:0] sh_r;
   logic ack_r;
   logic arb_r;

   bit_sync #(.W(2)) u_back (
      .clk(REF_CLK),
      .rst_n(RESET_N),
      .d({done_tog_r, busy_r}),
      .q(back_s)
   );

   wire logic take = CMD_VALID && ready_r;
   wire logic done_edge = back_s[1] ^ done_prev_r;

   // command words stay still until the done toggle returns, so the link
   // side may read them directly
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         ready_r <= 1'b1;
         req_tog_r <= 1'b0;
         done_prev_r <= 1'b0;
         done_r <= 1'b0;
         cmd_hold_r <= 2'h0;
         data_hold_r <= 8'h00;
         nack_hold_r <= 1'b0;
         rx_out_r <= 8'h00;
         nack_out_r <= 1'b0;
         arb_out_r <= 1'b0;
      end else begin
         done_prev_r <= back_s[1];
         done_r <= done_edge;
         if (take) begin
            cmd_hold_r <= CMD;
            data_hold_r <= CMD_DATA;
            nack_hold_r <= CMD_NACK;
            req_tog_r <= ~req_tog_r;
            ready_r <= 1'b0;
         end else if (done_edge) begin
            ready_r <= 1'b1;
            rx_out_r <= sh_r;
            nack_out_r <= ack_r;
            arb_out_r <= arb_r;
         end
      end
   end

   assign CMD_READY = ready_r;
   assign DONE = done_r;
   assign RX_DATA = rx_out_r;
   assign NACK_SEEN = nack_out_r;
   assign ARB_LOST = arb_out_r;
   assign BUS_BUSY = back_s[0];

   // ----------------------------------------
   // link side, link clock
   // ----------------------------------------
   logic lrst_n;
   logic [3:0] in_s;
   mstate_t state_r;
   logic [1:0] ph_r;
   logic [7:0] cnt_r;
   logic [3:0] bit_r;
   logic owned_r;
   logic scl_oe_r;
   logic sda_oe_r;
   logic scl_p_r;
   logic sda_p_r;
   logic req_seen_r;
   logic zero_r;

   bit_sync #(.W(1)) u_lrst (
      .clk(LINK_CLK),
      .rst_n(RESET_N),
      .d(1'b1),
      .q(lrst_n)
   );

   bit_sync #(.W(4)) u_lin (
      .clk(LINK_CLK),
      .rst_n(lrst_n),
      .d({BUS.bus_clock_line, BUS.bus_data_line, SERIAL_PORT_ENABLE, req_tog_r}),
      .q(in_s)
   );

   wire logic scl_s = in_s[3];
   wire logic sda_s = in_s[2];
   wire logic en_s = in_s[1];
   wire logic req_s = in_s[0];

   wire logic start_det = scl_s && scl_p_r && sda_p_r && !sda_s;
   wire logic stop_det = scl_s && scl_p_r && !sda_p_r && sda_s;
   wire logic busy_nxt = start_det ? 1'b1 : (stop_det ? 1'b0 : busy_r);

   wire logic is_wr = cmd_hold_r == i2c_engine_pkg::CMD_WRITE;
   wire logic last_bit = bit_r == i2c_engine_pkg::BIT_ACK;
   wire logic go = (req_s != req_seen_r) && (state_r == ST_IDLE);
   wire logic refuse = go && (!en_s || (cmd_hold_r != i2c_engine_pkg::CMD_START && !owned_r));
   wire logic abort = (state_r != ST_IDLE) && !en_s;
   // stretched clock holds the high phase until the line is really high
   wire logic stretch_wait = (ph_r == 2'h1) && !scl_s;
   // an unowned start waits for a stop, which also covers a lost arbitration
   wire logic busy_wait = (state_r == ST_START) && !owned_r && busy_r && (ph_r == 2'h0);
   wire logic stall = stretch_wait || busy_wait;
   wire logic step = (state_r != ST_IDLE) && (cnt_r == 8'h00) && !stall;
   // a released bit read back low means another transmitter won
   wire logic lost = step && (ph_r == 2'h1) && !sda_s &&
      ((state_r == ST_START) || ((state_r == ST_BIT) && is_wr && !last_bit && !sda_oe_r));
   wire logic seg_end = step && (ph_r == 2'h3) && ((state_r != ST_BIT) || last_bit);
   wire logic fail = refuse || lost || abort;
   wire logic finish = fail || seg_end;
   wire logic [3:0] nb = bit_r + 4'h1;
   wire logic next_low = is_wr ? ((nb < i2c_engine_pkg::BIT_ACK) && !sh_r[7]) :
      ((nb == i2c_engine_pkg::BIT_ACK) && !nack_hold_r);
   wire logic [7:0] cnt_nxt = ((state_r == ST_IDLE) || stall || (cnt_r == 8'h00)) ?
      (QUARTER - 8'h01) : (cnt_r - 8'h01);

   always_ff @(posedge LINK_CLK or negedge lrst_n) begin
      if (!lrst_n) begin
         state_r <= ST_IDLE;
         ph_r <= 2'h0;
         cnt_r <= 8'h00;
         bit_r <= i2c_engine_pkg::BIT_FIRST;
         sh_r <= 8'h00;
         owned_r <= 1'b0;
         scl_oe_r <= 1'b0;
         sda_oe_r <= 1'b0;
         ack_r <= 1'b0;
         arb_r <= 1'b0;
         done_tog_r <= 1'b0;
         busy_r <= 1'b0;
         scl_p_r <= 1'b1;
         sda_p_r <= 1'b1;
         req_seen_r <= 1'b0;
         zero_r <= 1'b0;
      end else begin
         scl_p_r <= scl_s;
         sda_p_r <= sda_s;
         zero_r <= 1'b0;
         busy_r <= busy_nxt;
         cnt_r <= cnt_nxt;
         if (go) begin
            req_seen_r <= req_s;
         end
         if (finish) begin
            state_r <= ST_IDLE;
            done_tog_r <= ~done_tog_r;
            arb_r <= fail;
            if (fail || (state_r == ST_STOP)) begin
               owned_r <= 1'b0;
               scl_oe_r <= 1'b0;
               sda_oe_r <= 1'b0;
            end
         end else if (go) begin
            ph_r <= 2'h0;
            bit_r <= i2c_engine_pkg::BIT_FIRST;
            sh_r <= data_hold_r;
            case (cmd_hold_r)
               i2c_engine_pkg::CMD_START: begin
                  state_r <= ST_START;
                  sda_oe_r <= 1'b0;
               end
               i2c_engine_pkg::CMD_WRITE: begin
                  state_r <= ST_BIT;
                  sda_oe_r <= !data_hold_r[7];
               end
               i2c_engine_pkg::CMD_READ: begin
                  state_r <= ST_BIT;
                  sda_oe_r <= 1'b0;
               end
               default: begin
                  state_r <= ST_STOP;
                  sda_oe_r <= 1'b1;
               end
            endcase
         end else if (step) begin
            ph_r <= ph_r + 2'h1;
            case (ph_r)
               2'h0: begin
                  scl_oe_r <= 1'b0;
               end
               2'h1: begin
                  if (state_r == ST_BIT) begin
                     if (last_bit) begin
                        ack_r <= sda_s;
                     end else begin
                        sh_r <= {sh_r[6:0], sda_s};
                     end
                  end else if (state_r == ST_START) begin
                     sda_oe_r <= 1'b1;
                  end
               end
               2'h2: begin
                  if (state_r == ST_STOP) begin
                     sda_oe_r <= 1'b0;
                  end else begin
                     scl_oe_r <= 1'b1;
                     if (state_r == ST_START) begin
                        owned_r <= 1'b1;
                     end
                  end
               end
               default: begin
                  // each later data bit moves here, with the clock held low; the first is set at go
                  bit_r <= nb;
                  sda_oe_r <= next_low;
               end
            endcase
         end
      end
   end

   // ----------------------------------------
   // pins: open drain, released on disable only mid-segment or when the next command is refused
   // ----------------------------------------
   assign BUS.m_scl_oe = scl_oe_r;
   assign BUS.m_sda_oe = sda_oe_r;
   assign BUS.m_scl_o = zero_r;
   assign BUS.m_sda_o = zero_r;
endmodule

// ==== rtl/i2c_slave_end.sv ====
`timescale 1ns/1ns
module i2c_slave_end #(
   parameter logic [6:0] OWN_ADDR = i2c_engine_pkg::SLAVE_ADDR_DEFAULT
) (
   input wire logic REF_CLK,
   input wire logic RESET_N,
   i2c_bus_if.partner BUS,
   input wire logic [7:0] TX_DATA,
   input wire logic STRETCH,
   output logic [7:0] RX_DATA,
   output logic RX_VALID,
   output logic TX_TAKEN,
   output logic ADDRESSED
);
   typedef enum logic [3:0] {
      SL_IDLE = 4'h1,
      SL_ADDR = 4'h2,
      SL_RX   = 4'h4,
      SL_TX   = 4'h8
   } sstate_t;

   // ----------------------------------------
   // line sampling and condition detection
   // ----------------------------------------
   logic [1:0] pin_s;
   sstate_t state_r;
   logic [3:0] bit_r;
   logic [7:0] sh_r;
   logic [7:0] tx_sh_r;
   logic after_ack_r;
   logic scl_p_r;
   logic sda_p_r;
   logic scl_oe_r;
   logic sda_oe_r;
   logic rx_valid_r;
   logic [7:0] rx_data_r;
   logic tx_taken_r;
   logic addressed_r;
   logic zero_r;

   bit_sync #(.W(2)) u_pin (
      .clk(REF_CLK),
      .rst_n(RESET_N),
      .d({BUS.bus_clock_line, BUS.bus_data_line}),
      .q(pin_s)
   );

   wire logic scl_s = pin_s[1];
   wire logic sda_s = pin_s[0];
   wire logic rise = scl_s && !scl_p_r;
   wire logic fall = !scl_s && scl_p_r;
   wire logic start_det = scl_s && scl_p_r && sda_p_r && !sda_s;
   wire logic stop_det = scl_s && scl_p_r && !sda_p_r && sda_s;
   wire logic active = state_r != SL_IDLE;
   wire logic last_bit = bit_r == i2c_engine_pkg::BIT_ACK;
   wire logic match = sh_r[7:1] == OWN_ADDR;
   wire logic ack_fall = fall && active && after_ack_r;
   // hold the clock low after an acknowledge until the user lets go
   wire logic scl_hold_nxt = STRETCH && !start_det && !stop_det && (scl_oe_r || ack_fall);
   wire logic [2:0] tx_idx = 3'h7 - bit_r[2:0];

   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         state_r <= SL_IDLE;
         bit_r <= i2c_engine_pkg::BIT_FIRST;
         sh_r <= 8'h00;
         tx_sh_r <= 8'h00;
         after_ack_r <= 1'b0;
         scl_p_r <= 1'b1;
         sda_p_r <= 1'b1;
         scl_oe_r <= 1'b0;
         sda_oe_r <= 1'b0;
         rx_valid_r <= 1'b0;
         rx_data_r <= 8'h00;
         tx_taken_r <= 1'b0;
         addressed_r <= 1'b0;
         zero_r <= 1'b0;
      end else begin
         scl_p_r <= scl_s;
         sda_p_r <= sda_s;
         zero_r <= 1'b0;
         rx_valid_r <= 1'b0;
         tx_taken_r <= 1'b0;
         scl_oe_r <= scl_hold_nxt;
         addressed_r <= (state_r == SL_RX) || (state_r == SL_TX);
         if (start_det) begin
            state_r <= SL_ADDR;
            bit_r <= i2c_engine_pkg::BIT_FIRST;
            after_ack_r <= 1'b0;
            sda_oe_r <= 1'b0;
         end else if (stop_det) begin
            state_r <= SL_IDLE;
            bit_r <= i2c_engine_pkg::BIT_FIRST;
            after_ack_r <= 1'b0;
            sda_oe_r <= 1'b0;
         end else if (rise && active) begin
            if (last_bit) begin
               bit_r <= i2c_engine_pkg::BIT_FIRST;
               after_ack_r <= 1'b1;
               // a master that does not acknowledge ends the read
               if ((state_r == SL_TX) && sda_s) begin
                  state_r <= SL_IDLE;
               end
            end else begin
               sh_r <= {sh_r[6:0], sda_s};
               bit_r <= bit_r + 4'h1;
            end
         end else if (fall && active) begin
            after_ack_r <= 1'b0;
            if (last_bit) begin
               case (state_r)
                  SL_ADDR: begin
                     if (match) begin
                        sda_oe_r <= 1'b1;
                     end else begin
                        state_r <= SL_IDLE;
                     end
                  end
                  SL_RX: begin
                     sda_oe_r <= 1'b1;
                     rx_valid_r <= 1'b1;
                     rx_data_r <= sh_r;
                  end
                  default: begin
                     sda_oe_r <= 1'b0;
                  end
               endcase
            end else if (after_ack_r) begin
               sda_oe_r <= 1'b0;
               if (((state_r == SL_ADDR) && sh_r[0]) || (state_r == SL_TX)) begin
                  state_r <= SL_TX;
                  tx_sh_r <= TX_DATA;
                  sda_oe_r <= !TX_DATA[7];
                  tx_taken_r <= 1'b1;
               end else begin
                  state_r <= SL_RX;
               end
            end else if (state_r == SL_TX) begin
               sda_oe_r <= !tx_sh_r[tx_idx];
            end
         end
      end
   end

   assign BUS.s_scl_oe = scl_oe_r;
   assign BUS.s_sda_oe = sda_oe_r;
   assign BUS.s_scl_o = zero_r;
   assign BUS.s_sda_o = zero_r;
   assign RX_DATA = rx_data_r;
   assign RX_VALID = rx_valid_r;
   assign TX_TAKEN = tx_taken_r;
   assign ADDRESSED = addressed_r;
endmodule

// ==== testbench/i2c_bus_protocol_engine_assertions.sv ====
`timescale 1ns/1ns
module i2c_bus_protocol_engine_assertions (
   input wire logic ref_clk,
   input wire logic link_clk,
   input wire logic reset_n,
   input wire logic m_scl_o,
   input wire logic m_scl_oe,
   input wire logic m_sda_o,
   input wire logic m_sda_oe,
   input wire logic s_scl_o,
   input wire logic s_scl_oe,
   input wire logic s_sda_o,
   input wire logic s_sda_oe,
   input wire logic bus_clock_line,
   input wire logic bus_data_line
);
   // ----------------------------------------
   // line levels and pin values
   // ----------------------------------------
   chk_pins_tied_zero: assert property (
      @(posedge link_clk) disable iff (!reset_n) !(m_scl_o || m_sda_o || s_scl_o || s_sda_o))
      else $error("pin output value not zero");
   chk_clock_wired_and: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      bus_clock_line == !((m_scl_oe && !m_scl_o) || (s_scl_oe && !s_scl_o)))
      else $error("clock line level wrong");
   chk_data_wired_and: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      bus_data_line == !((m_sda_oe && !m_sda_o) || (s_sda_oe && !s_sda_o)))
      else $error("data line level wrong");
   // ----------------------------------------
   // framing and flow control
   // ----------------------------------------
   // the slave end never makes a start or stop, so any change of its data is an ordinary bit
   chk_slave_data_clock_low: assert property (
      @(posedge ref_clk) disable iff (!reset_n) $changed(s_sda_oe) |-> !bus_clock_line)
      else $error("slave changed data while clock high");
   chk_slave_stretch_low: assert property (
      @(posedge ref_clk) disable iff (!reset_n) $rose(s_scl_oe) |-> !$past(bus_clock_line))
      else $error("slave pulled clock while it was high");
   chk_master_waits_stretch: assert property (
      @(posedge link_clk) disable iff (!reset_n) !m_scl_oe && s_scl_oe |=> !m_scl_oe)
      else $error("master pulled clock during stretch");
   chk_start_then_clock: assert property (
      @(posedge link_clk) disable iff (!reset_n)
      $rose(m_sda_oe) && !m_scl_oe |-> m_sda_oe throughout (##[1:40] m_scl_oe))
      else $error("start not followed by clock low");
   chk_stop_leaves_idle: assert property (
      @(posedge link_clk) disable iff (!reset_n) $fell(m_sda_oe) && !m_scl_oe |=> (!m_scl_oe)[*4])
      else $error("clock pulled right after stop");
   cov_stretch: cover property (@(posedge ref_clk) disable iff (!reset_n) $rose(s_scl_oe));
   cov_start: cover property (@(posedge link_clk) disable iff (!reset_n)
      $rose(m_sda_oe) && !m_scl_oe);
   cov_stop: cover property (@(posedge link_clk) disable iff (!reset_n)
      $fell(m_sda_oe) && !m_scl_oe);
endmodule

// ==== testbench/tb_i2c_bus_protocol_engine.sv ====
`timescale 1ns/1ns
module tb_i2c_bus_protocol_engine;
   localparam logic [6:0] ADDR = i2c_engine_pkg::SLAVE_ADDR_DEFAULT;
   logic ref_clk = 1'b0;
   logic link_clk = 1'b0;
   logic reset_n = 1'b0;
   logic [1:0] en = 2'b11;
   logic [1:0] vld = 2'b00;
   logic [1:0] cmd = 2'h0;
   logic [7:0] cmd_data = 8'h00;
   logic cmd_nack = 1'b0;
   logic [7:0] tx_data = 8'h3C;
   logic stretch = 1'b0;
   logic hold2 = 1'b0;
   logic [1:0] rdy, done, nack_seen, arb, busy;
   logic [7:0] rx [2];
   logic [7:0] s_rx;
   logic s_rx_valid, s_taken, s_addr;
   logic [8:0] seg = 9'h000;
   int starts = 0;
   int stops = 0;
   int rx_pulses = 0;
   int mismatches = 0;
   int samples_checked = 0;
   time t_rel, t_done;
   i2c_bus_if bus ();
   // second bus: the bench stands in for a rival master that only pulls data low
   i2c_bus_if bus2 ();
   assign bus2.s_scl_o = 1'b0;
   assign bus2.s_scl_oe = 1'b0;
   assign bus2.s_sda_o = 1'b0;
   assign bus2.s_sda_oe = hold2;
   initial forever #25 ref_clk = ~ref_clk;
   initial begin
      #13;
      forever #40 link_clk = ~link_clk;
   end
   i2c_master_end #(.QUARTER(i2c_engine_pkg::QUARTER_CYCLES)) i2c_master_end_i (
      .REF_CLK(ref_clk), .RESET_N(reset_n), .LINK_CLK(link_clk), .BUS(bus),
      .SERIAL_PORT_ENABLE(en[0]), .CMD_VALID(vld[0]), .CMD(cmd), .CMD_DATA(cmd_data),
      .CMD_NACK(cmd_nack), .CMD_READY(rdy[0]), .DONE(done[0]), .RX_DATA(rx[0]),
      .NACK_SEEN(nack_seen[0]), .ARB_LOST(arb[0]), .BUS_BUSY(busy[0]));
   i2c_master_end #(.QUARTER(i2c_engine_pkg::QUARTER_CYCLES)) rival_i2c_master_end_i (
      .REF_CLK(ref_clk), .RESET_N(reset_n), .LINK_CLK(link_clk), .BUS(bus2),
      .SERIAL_PORT_ENABLE(en[1]), .CMD_VALID(vld[1]), .CMD(cmd), .CMD_DATA(cmd_data),
      .CMD_NACK(cmd_nack), .CMD_READY(rdy[1]), .DONE(done[1]), .RX_DATA(rx[1]),
      .NACK_SEEN(nack_seen[1]), .ARB_LOST(arb[1]), .BUS_BUSY(busy[1]));
   i2c_slave_end #(.OWN_ADDR(ADDR)) i2c_slave_end_i (
      .REF_CLK(ref_clk), .RESET_N(reset_n), .BUS(bus), .TX_DATA(tx_data),
      .STRETCH(stretch), .RX_DATA(s_rx), .RX_VALID(s_rx_valid), .TX_TAKEN(s_taken),
      .ADDRESSED(s_addr));
   i2c_bus_protocol_engine_assertions i2c_bus_protocol_engine_assertions_i (
      .ref_clk(ref_clk), .link_clk(link_clk), .reset_n(reset_n),
      .m_scl_o(bus.m_scl_o), .m_scl_oe(bus.m_scl_oe), .m_sda_o(bus.m_sda_o),
      .m_sda_oe(bus.m_sda_oe), .s_scl_o(bus.s_scl_o), .s_scl_oe(bus.s_scl_oe),
      .s_sda_o(bus.s_sda_o), .s_sda_oe(bus.s_sda_oe), .bus_clock_line(bus.bus_clock_line),
      .bus_data_line(bus.bus_data_line));
   // ----------------------------------------
   // wire watcher: last nine sampled bits, start and stop counts
   // ----------------------------------------
   always @(posedge bus.bus_clock_line) seg <= {seg[7:0], bus.bus_data_line};
   always @(negedge bus.bus_data_line) if (bus.bus_clock_line === 1'b1) starts++;
   always @(posedge bus.bus_data_line) if (bus.bus_clock_line === 1'b1) stops++;
   // next byte for the slave once the first one is taken
   always @(negedge ref_clk) if (s_taken === 1'b1) tx_data <= 8'hC3;
   // one receive pulse per data byte written to the slave, none for address bytes
   always @(negedge ref_clk) if (s_rx_valid === 1'b1) rx_pulses++;
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic cmpv(input string nm, input logic [15:0] e, input logic [15:0] g);
      samples_checked++;
      if (g !== e) begin
         mismatches++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cmpf(input string nm, input logic e, input logic g);
      samples_checked++;
      if (g !== e) begin
         mismatches++;
         $display("Error %s expected %b seen %b", nm, e, g);
      end
   endtask
   task automatic go(input int m, input i2c_engine_pkg::cmd_t c, input logic [7:0] d,
                     input logic nk);
      int n;
      n = 0;
      @(negedge ref_clk);
      cmd = c;
      cmd_data = d;
      cmd_nack = nk;
      vld[m] = 1'b1;
      while (rdy[m] !== 1'b1) @(negedge ref_clk);
      @(negedge ref_clk);
      vld[m] = 1'b0;
      while (done[m] !== 1'b1 && n < 6000) begin
         @(negedge ref_clk);
         n++;
      end
      t_done = $time;
      cmpf("done", 1'b1, done[m]);
   endtask
   task automatic conclude();
      if (mismatches == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge ref_clk);
      mismatches++;
      conclude();
   end
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      repeat (10) @(negedge ref_clk);
      reset_n = 1'b1;
      repeat (5) @(negedge ref_clk);
      starts = 0;
      stops = 0;
      go(0, i2c_engine_pkg::CMD_WRITE, 8'h11, 1'b0);
      cmpf("unowned_write", 1'b1, arb[0]);
      go(0, i2c_engine_pkg::CMD_START, 8'h00, 1'b0);
      cmpf("busy", 1'b1, busy[0]);
      cmpv("starts", 16'h0001, 16'(starts));
      go(0, i2c_engine_pkg::CMD_WRITE, {ADDR, 1'b0}, 1'b0);
      cmpf("addr_nack", 1'b0, nack_seen[0]);
      cmpv("addr_bits", {7'h00, ADDR, 1'b0, 1'b0}, {7'h00, seg});
      cmpf("addressed", 1'b1, s_addr);
      go(0, i2c_engine_pkg::CMD_WRITE, 8'hA5, 1'b0);
      cmpv("write_bits", {7'h00, 8'hA5, 1'b0}, {7'h00, seg});
      cmpv("slave_rx", 16'h00A5, {8'h00, s_rx});
      cmpv("readback", 16'h00A5, {8'h00, rx[0]});
      go(0, i2c_engine_pkg::CMD_STOP, 8'h00, 1'b0);
      cmpf("idle", 1'b0, busy[0]);
      cmpv("stops", 16'h0001, 16'(stops));
      go(0, i2c_engine_pkg::CMD_START, 8'h00, 1'b0);
      go(0, i2c_engine_pkg::CMD_WRITE, {ADDR, 1'b1}, 1'b0);
      cmpv("read_addr_bits", {7'h00, ADDR, 1'b1, 1'b0}, {7'h00, seg});
      go(0, i2c_engine_pkg::CMD_READ, 8'h00, 1'b0);
      cmpv("read_data", 16'h003C, {8'h00, rx[0]});
      cmpv("read_ack_bits", {7'h00, 8'h3C, 1'b0}, {7'h00, seg});
      go(0, i2c_engine_pkg::CMD_READ, 8'h00, 1'b1);
      cmpv("read_last_bits", {7'h00, 8'hC3, 1'b1}, {7'h00, seg});
      go(0, i2c_engine_pkg::CMD_START, 8'h00, 1'b0);
      cmpv("restart_count", 16'h0003, 16'(starts));
      cmpv("restart_stops", 16'h0001, 16'(stops));
      cmpf("restart_busy", 1'b1, busy[0]);
      go(0, i2c_engine_pkg::CMD_WRITE, {7'h15, 1'b0}, 1'b0);
      cmpf("absent_nack", 1'b1, nack_seen[0]);
      cmpf("not_addressed", 1'b0, s_addr);
      go(0, i2c_engine_pkg::CMD_STOP, 8'h00, 1'b0);
      go(0, i2c_engine_pkg::CMD_START, 8'h00, 1'b0);
      go(0, i2c_engine_pkg::CMD_WRITE, {ADDR, 1'b0}, 1'b0);
      stretch = 1'b1;
      fork
         begin
            go(0, i2c_engine_pkg::CMD_WRITE, 8'h5A, 1'b0);
            go(0, i2c_engine_pkg::CMD_WRITE, 8'h96, 1'b0);
         end
         begin
            repeat (800) @(negedge ref_clk);
            t_rel = $time;
            stretch = 1'b0;
         end
      join
      cmpf("stretch_wait", 1'b1, t_done > t_rel);
      cmpv("stretch_rx", 16'h0096, {8'h00, s_rx});
      cmpv("rx_pulses", 16'h0003, 16'(rx_pulses));
      go(0, i2c_engine_pkg::CMD_STOP, 8'h00, 1'b0);
      en[0] = 1'b0;
      repeat (10) @(negedge ref_clk);
      go(0, i2c_engine_pkg::CMD_START, 8'h00, 1'b0);
      cmpf("disabled_start", 1'b1, arb[0]);
      en[0] = 1'b1;
      hold2 = 1'b1;
      repeat (40) @(negedge ref_clk);
      cmpf("foreign_busy", 1'b1, busy[1]);
      fork
         go(1, i2c_engine_pkg::CMD_START, 8'h00, 1'b0);
         begin
            repeat (200) @(negedge ref_clk);
            #1 cmpf("start_held", 1'b0, rdy[1]);
            hold2 = 1'b0;
         end
      join
      cmpf("start_after_stop", 1'b0, arb[1]);
      fork
         go(1, i2c_engine_pkg::CMD_WRITE, 8'hFF, 1'b0);
         begin
            @(negedge bus2.bus_clock_line);
            hold2 = 1'b1;
         end
      join
      cmpf("arb_lost", 1'b1, arb[1]);
      cmpf("lost_scl_oe", 1'b0, bus2.m_scl_oe);
      cmpf("lost_sda_oe", 1'b0, bus2.m_sda_oe);
      hold2 = 1'b0;
      repeat (40) @(negedge ref_clk);
      cmpf("lost_idle", 1'b0, busy[1]);
      conclude();
   end
endmodule
